/* hw/aac_regs.sv */
// Control and report register bank of a four-channel class-D amplifier.
// Assumes a control-bus front end giving byte-wide write and read strobes,
// and analog load-check logic reporting results with a done pulse.
`timescale 1ns/100ps

module aac_regs
  import aac_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output aac_pkg::aac_port_cfg_s port_cfg,
  output logic [7:0] state_cmd,
  output logic [31:0] gain_level,
  output logic [3:0] vol_mute,
  output aac_pkg::aac_check_cfg_s check_cfg,
  output logic check_abort,
  output logic [3:0] auto_check_req,
  input wire logic [3:0] chan_fault,
  input wire logic [7:0] state_actual,
  input wire logic check_done,
  input wire aac_pkg::aac_check_res_s check_res
);
  import aac_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] port_fmt_r;
  logic [7:0] state_sel_r;
  logic [7:0] vol_r [4];
  logic [7:0] check_ctl_r;
  logic [7:0] thr12_r;
  logic [7:0] thr34_r;
  logic [7:0] res12_r;
  logic [7:0] res34_r;
  logic [3:0] lineout_r;
  logic [7:0] rdata_nxt;
  logic [3:0] fault_q_r;
  logic [3:0] auto_req_nxt;

  // Volume code muting test, used per channel
  function automatic logic vol_is_mute(input logic [7:0] code);
    return code < AAC_VOL_MUTE_BELOW;
  endfunction

  // Doubling of a timing count when its bit is set
  function automatic logic [11:0] time_scale(input logic [11:0] base, input logic dbl);
    return dbl ? 12'(base << 1) : base;
  endfunction

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  wire wr_fmt = reg_wr && (reg_addr == AAC_ADDR_PORT_FMT);
  wire wr_state = reg_wr && (reg_addr == AAC_ADDR_STATE_SEL);
  wire wr_chk = reg_wr && (reg_addr == AAC_ADDR_CHECK_CTL);
  wire wr_thr12 = reg_wr && (reg_addr == AAC_ADDR_THR_CH12);
  wire wr_thr34 = reg_wr && (reg_addr == AAC_ADDR_THR_CH34);
  wire vol_hit = (reg_addr >= AAC_ADDR_VOL_ONE) && (reg_addr <= AAC_ADDR_VOL_FOUR);
  wire [1:0] vol_idx = 2'(reg_addr - AAC_ADDR_VOL_ONE);

  // ----------------------------------------
  // Writable registers
  // ----------------------------------------
  // Serial port format, rate, slot and swap
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      port_fmt_r <= AAC_RST_PORT_FMT;
    end else if (wr_fmt) begin
      port_fmt_r <= reg_wdata;
    end
  end

  // Commanded channel states
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_sel_r <= AAC_RST_STATE_SEL;
    end else if (wr_state) begin
      state_sel_r <= reg_wdata;
    end
  end

  // One volume byte per channel
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 4; i++) begin
        vol_r[i] <= AAC_RST_VOL;
      end
    end else if (reg_wr && vol_hit) begin
      vol_r[vol_idx] <= reg_wdata;
    end
  end

  // Load check control, reserved bits kept zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      check_ctl_r <= AAC_RST_CHECK_CTL;
    end else if (wr_chk) begin
      check_ctl_r <= reg_wdata & AAC_CHK_WRITE_MASK;
    end
  end

  // Shorted-load thresholds, two channels per byte
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      thr12_r <= AAC_RST_THR;
      thr34_r <= AAC_RST_THR;
    end else begin
      if (wr_thr12) begin
        thr12_r <= reg_wdata;
      end
      if (wr_thr34) begin
        thr34_r <= reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Report capture
  // ----------------------------------------
  // Results load only at the end of a run and hold otherwise
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      res12_r <= AAC_RST_REPORT;
      res34_r <= AAC_RST_REPORT;
      lineout_r <= '0;
    end else if (check_done) begin
      res12_r <= check_res.flags[15:8];
      res34_r <= check_res.flags[7:0];
      lineout_r <= check_cfg.lineout_en ? check_res.lineout : '0;
    end
  end

  // ----------------------------------------
  // Automatic checks and abort
  // ----------------------------------------
  // Leaving hiz by command, or a new channel fault, asks for a check
  always_comb begin
    auto_req_nxt = '0;
    for (int i = 0; i < 4; i++) begin
      if (!check_ctl_r[AAC_CHK_SKIP_BIT]) begin
        auto_req_nxt[i] = (chan_fault[i] && !fault_q_r[i])
          || (wr_state && (state_sel_r[2*i +: 2] == AAC_HIZ_CODE)
          && (reg_wdata[2*i +: 2] != AAC_HIZ_CODE));
      end
    end
  end

  // Request pulses, fault history and abort strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      auto_check_req <= '0;
      fault_q_r <= '0;
      check_abort <= 1'b0;
    end else begin
      auto_check_req <= auto_req_nxt;
      fault_q_r <= chan_fault;
      check_abort <= wr_chk && reg_wdata[AAC_CHK_ABORT_BIT];
    end
  end

  // ----------------------------------------
  // Decoded outputs
  // ----------------------------------------
  // Serial port setup
  assign port_cfg.rate = aac_rate_e'(port_fmt_r[AAC_FMT_RATE_LSB +: 2]);
  assign port_cfg.last_slots = port_fmt_r[AAC_FMT_GROUP_BIT];
  assign port_cfg.slot_base = port_fmt_r[AAC_FMT_GROUP_BIT] ? AAC_SLOT_LAST_FIRST : 3'h0;
  assign port_cfg.slot16 = port_fmt_r[AAC_FMT_WIDTH_BIT];
  assign port_cfg.swap_pairs = port_fmt_r[AAC_FMT_SWAP_BIT];
  assign port_cfg.fmt = aac_fmt_e'(port_fmt_r[2:0]);

  // Channel commands and volume
  assign state_cmd = state_sel_r;
  assign gain_level = {vol_r[0], vol_r[1], vol_r[2], vol_r[3]};
  assign vol_mute = {vol_is_mute(vol_r[0]), vol_is_mute(vol_r[1]),
                     vol_is_mute(vol_r[2]), vol_is_mute(vol_r[3])};

  // Load check setup
  assign check_cfg.ramp_cyc = time_scale(AAC_RAMP_CYC, check_ctl_r[AAC_CHK_RAMP_BIT]);
  assign check_cfg.settle_cyc =
    time_scale(AAC_SETTLE_CYC, check_ctl_r[AAC_CHK_SETTLE_BIT]);
  assign check_cfg.lineout_en = check_ctl_r[AAC_CHK_LINEOUT_BIT];
  assign check_cfg.short_thr = {thr12_r, thr34_r};

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Read mux, unmapped offsets read zero
  always_comb begin
    if (reg_addr == AAC_ADDR_PORT_FMT) begin
      rdata_nxt = port_fmt_r;
    end else if (reg_addr == AAC_ADDR_STATE_SEL) begin
      rdata_nxt = state_sel_r;
    end else if (vol_hit) begin
      rdata_nxt = vol_r[vol_idx];
    end else if (reg_addr == AAC_ADDR_CHECK_CTL) begin
      rdata_nxt = check_ctl_r;
    end else if (reg_addr == AAC_ADDR_THR_CH12) begin
      rdata_nxt = thr12_r;
    end else if (reg_addr == AAC_ADDR_THR_CH34) begin
      rdata_nxt = thr34_r;
    end else if (reg_addr == AAC_ADDR_RES_CH12) begin
      rdata_nxt = res12_r;
    end else if (reg_addr == AAC_ADDR_LINEOUT_RES) begin
      rdata_nxt = {4'h0, lineout_r};
    end else if (reg_addr == AAC_ADDR_STATE_RPT) begin
      rdata_nxt = state_actual;
    end else begin
      rdata_nxt = AAC_READ_ZERO;
    end
  end

  // Read data registered one cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= AAC_READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_rate_write: assert property (
    wr_fmt |=> port_cfg.rate == aac_rate_e'($past(reg_wdata[7:6])))
    else $error("rate field not taken from write");
  a_slot_base: assert property (
    wr_fmt |=> port_cfg.slot_base == ($past(reg_wdata[5]) ? 3'h4 : 3'h0))
    else $error("slot base does not follow group bit");
  a_swap_write: assert property (
    wr_fmt |=> port_cfg.swap_pairs == $past(reg_wdata[3])
      && port_cfg.slot16 == $past(reg_wdata[4]))
    else $error("swap or width bit not stored");
  a_vol_write: assert property (
    reg_wr && reg_addr == 8'h06 |=> gain_level[23:16] == $past(reg_wdata))
    else $error("channel two volume not stored");
  a_vol_mute: assert property (
    vol_mute[3] == (gain_level[31:24] < 8'h07))
    else $error("channel one mute wrong");
  a_abort_pulse: assert property (
    wr_chk && reg_wdata[7] |=> check_abort ##1 !check_abort || $past(wr_chk))
    else $error("abort strobe wrong");
  a_ramp_double: assert property (
    check_ctl_r[6] |-> check_cfg.ramp_cyc == 12'd800)
    else $error("ramp not doubled");
  a_settle_time: assert property (
    !check_ctl_r[5] |-> check_cfg.settle_cyc == 12'd800)
    else $error("settle time not normal");
  a_lineout_off: assert property (
    check_done && !check_ctl_r[1] |=> lineout_r == 4'h0)
    else $error("line output report set while disabled");
  a_auto_skip: assert property (
    check_ctl_r[0] |=> auto_check_req == 4'h0)
    else $error("automatic check while skipped");
  a_report_hold: assert property (
    !check_done |=> $stable(res12_r))
    else $error("report changed outside run end");
  a_report_load: assert property (
    check_done |=> res12_r == $past(check_res.flags[15:8]))
    else $error("report not loaded at run end");
  a_read_answer: assert property (
    reg_rd && reg_addr == 8'h0F |=> reg_rvalid && reg_rdata == $past(state_actual))
    else $error("state report read wrong");

  // Serial port and channel command fields
  a_fmt_write: assert property (
    wr_fmt |=> port_cfg.fmt == aac_fmt_e'($past(reg_wdata[2:0])))
    else $error("input format not taken from write");
  a_group_bit: assert property (
    wr_fmt |=> port_cfg.last_slots == $past(reg_wdata[5]))
    else $error("slot group bit not stored");
  a_rate_read: assert property (
    reg_rd && reg_addr == 8'h03 |=> reg_rdata[7:6] == $past(port_cfg.rate))
    else $error("rate field read wrong");
  a_state_write: assert property (
    wr_state |=> state_cmd == $past(reg_wdata))
    else $error("channel states not stored");
  a_state_read: assert property (
    reg_rd && reg_addr == 8'h04 |=> reg_rdata == $past(state_cmd))
    else $error("channel states read wrong");

  // Volume bytes
  a_vol_one: assert property (
    reg_wr && reg_addr == 8'h05 |=> gain_level[31:24] == $past(reg_wdata))
    else $error("channel one volume not stored");
  a_vol_three: assert property (
    reg_wr && reg_addr == 8'h07 |=> gain_level[15:8] == $past(reg_wdata))
    else $error("channel three volume not stored");
  a_vol_four: assert property (
    reg_wr && reg_addr == 8'h08 |=> gain_level[7:0] == $past(reg_wdata))
    else $error("channel four volume not stored");
  a_mute_four: assert property (
    vol_mute[0] == (gain_level[7:0] < 8'h07))
    else $error("channel four mute wrong");

  // Load check setup
  a_ramp_normal: assert property (
    !check_ctl_r[6] |-> check_cfg.ramp_cyc == 12'h190)
    else $error("ramp time not normal");
  a_settle_double: assert property (
    check_ctl_r[5] |-> check_cfg.settle_cyc == 12'h640)
    else $error("settle time not doubled");
  a_abort_quiet: assert property (
    wr_chk && !reg_wdata[7] |=> !check_abort)
    else $error("abort strobe without abort bit");
  a_thr12_write: assert property (
    reg_wr && reg_addr == 8'h0A |=> check_cfg.short_thr[15:8] == $past(reg_wdata))
    else $error("channel one and two thresholds not stored");
  a_thr34_write: assert property (
    reg_wr && reg_addr == 8'h0B |=> check_cfg.short_thr[7:0] == $past(reg_wdata))
    else $error("channel three and four thresholds not stored");
  a_thr_read: assert property (
    reg_rd && reg_addr == 8'h0A |=> reg_rdata == $past(check_cfg.short_thr[15:8]))
    else $error("threshold read wrong");

  // Reports and automatic requests
  a_lineout_load: assert property (
    check_done && check_ctl_r[1] |=> lineout_r == $past(check_res.lineout))
    else $error("line output report not loaded");
  a_lineout_read: assert property (
    reg_rd && reg_addr == 8'h0E |=> reg_rdata == {4'h0, $past(lineout_r)})
    else $error("line output report read wrong");
  a_report_read: assert property (
    reg_rd && reg_addr == 8'h0C |=> reg_rdata == $past(res12_r))
    else $error("load report read wrong");
  a_report_two: assert property (
    check_done |=> res34_r == $past(check_res.flags[7:0]))
    else $error("second report not loaded at run end");
  a_leave_hiz: assert property (
    wr_state && !check_ctl_r[0] && state_sel_r[7:6] == 2'h1 && reg_wdata[7:6] != 2'h1
    |=> auto_check_req[3])
    else $error("no check request on leaving hiz");
  a_fault_req: assert property (
    !check_ctl_r[0] && chan_fault[1] && !fault_q_r[1] |=> auto_check_req[1])
    else $error("no check request after channel fault");

  c_auto_req: cover property (auto_check_req != 4'h0);
  c_abort: cover property (check_abort);
  c_run_done: cover property (check_done ##1 res12_r != 8'h00);
  c_vol_mute: cover property (vol_mute != 4'h0);
  c_lineout_found: cover property (check_done && check_cfg.lineout_en);

endmodule

/* include/aac_pkg.sv */
// Shared constants and types for the amplifier control register bank.
// Assumes one 40 MHz clock and an 8-bit register port from the control bus front end.
package aac_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] AAC_ADDR_PORT_FMT = 8'h03;
  localparam logic [7:0] AAC_ADDR_STATE_SEL = 8'h04;
  localparam logic [7:0] AAC_ADDR_VOL_ONE = 8'h05;
  localparam logic [7:0] AAC_ADDR_VOL_FOUR = 8'h08;
  localparam logic [7:0] AAC_ADDR_CHECK_CTL = 8'h09;
  localparam logic [7:0] AAC_ADDR_THR_CH12 = 8'h0A;
  localparam logic [7:0] AAC_ADDR_THR_CH34 = 8'h0B;
  localparam logic [7:0] AAC_ADDR_RES_CH12 = 8'h0C;
  localparam logic [7:0] AAC_ADDR_LINEOUT_RES = 8'h0E;
  localparam logic [7:0] AAC_ADDR_STATE_RPT = 8'h0F;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] AAC_RST_PORT_FMT = 8'h04;
  localparam logic [7:0] AAC_RST_STATE_SEL = 8'h55;
  localparam logic [7:0] AAC_RST_VOL = 8'hCF;
  localparam logic [7:0] AAC_RST_CHECK_CTL = 8'h00;
  localparam logic [7:0] AAC_RST_THR = 8'h11;
  localparam logic [7:0] AAC_RST_REPORT = 8'h00;
  localparam logic [7:0] AAC_READ_ZERO = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int AAC_FMT_RATE_LSB = 6;
  localparam int AAC_FMT_GROUP_BIT = 5;
  localparam int AAC_FMT_WIDTH_BIT = 4;
  localparam int AAC_FMT_SWAP_BIT = 3;
  localparam int AAC_CHK_ABORT_BIT = 7;
  localparam int AAC_CHK_RAMP_BIT = 6;
  localparam int AAC_CHK_SETTLE_BIT = 5;
  localparam int AAC_CHK_LINEOUT_BIT = 1;
  localparam int AAC_CHK_SKIP_BIT = 0;
  localparam logic [7:0] AAC_CHK_WRITE_MASK = 8'hE3;
  localparam logic [7:0] AAC_VOL_MUTE_BELOW = 8'h07;
  localparam logic [1:0] AAC_HIZ_CODE = 2'h1;
  localparam logic [2:0] AAC_SLOT_LAST_FIRST = 3'h4;

  // ----------------------------------------
  // Diagnostic timing (microseconds, then cycles at 40 MHz)
  // ----------------------------------------
  localparam int AAC_CLK_MHZ = 40;
  localparam int AAC_RAMP_US = 10;
  localparam int AAC_SETTLE_US = 20;
  localparam logic [11:0] AAC_RAMP_CYC = 12'(AAC_RAMP_US * AAC_CLK_MHZ);
  localparam logic [11:0] AAC_SETTLE_CYC = 12'(AAC_SETTLE_US * AAC_CLK_MHZ);

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {AAC_FS_44K1, AAC_FS_48K, AAC_FS_96K, AAC_FS_RSVD} aac_rate_e;
  typedef enum logic [2:0] {
    AAC_RJ24, AAC_RJ20, AAC_RJ18, AAC_RJ16, AAC_I2S, AAC_LJ, AAC_TDM, AAC_FMT_RSVD
  } aac_fmt_e;
  typedef enum logic [1:0] {AAC_PLAY, AAC_HIZ, AAC_MUTE, AAC_DIAG} aac_chstate_e;

  // Serial port setup handed to the audio receiver
  typedef struct packed {
    aac_rate_e rate;
    logic last_slots;
    logic slot16;
    logic swap_pairs;
    aac_fmt_e fmt;
    logic [2:0] slot_base;
  } aac_port_cfg_s;

  // Load check setup handed to the diagnostic engine
  typedef struct packed {
    logic [11:0] ramp_cyc;
    logic [11:0] settle_cyc;
    logic lineout_en;
    logic [15:0] short_thr;
  } aac_check_cfg_s;

  // Result of one load check run, four flags per channel, channel 1 high
  typedef struct packed {
    logic [15:0] flags;
    logic [3:0] lineout;
  } aac_check_res_s;

endpackage

/* tb/aac_host.sv */
// Host model driving the register port of the amplifier control bank.
// Assumes one clock; the bench calls its tasks one at a time.
`timescale 1ns/100ps

module aac_host (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic [7:0] reg_wdata,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end

  // One write, held until its taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d; // No stale data left on the lines
  endtask

  // One read; data and valid taken the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    v = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

/* tb/tb_aac_regs.sv */
// Self-checking bench for the amplifier control register bank.
// Assumes the host model for register traffic; the bench plays the check engine.
`timescale 1ns/100ps

module tb_aac_regs
  import aac_pkg::*;
;
  logic clk, resetn, reg_wr, reg_rd, reg_rvalid, check_abort, check_done;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, state_cmd, state_actual;
  logic [31:0] gain_level;
  logic [3:0] vol_mute, auto_check_req, chan_fault;
  aac_port_cfg_s port_cfg;
  aac_check_cfg_s check_cfg;
  aac_check_res_s check_res;
  int mismatches = 0;
  int cmp_count = 0;

  aac_regs dut (.clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
    .reg_rvalid, .port_cfg, .state_cmd, .gain_level, .vol_mute, .check_cfg, .check_abort,
    .auto_check_req, .chan_fault, .state_actual, .check_done, .check_res);
  aac_host host (.clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic v;
    host.rd(a, d, v);
    chk("reg_rvalid", 1, v);
    chk("reg_rdata", e, d);
    @(posedge clk);
    #1;
    chk("reg_rvalid_end", 0, reg_rvalid);
    chk("reg_rdata_hold", e, reg_rdata);
  endtask

  // Collects request pulses over three cycles; a pulse lasts one cycle
  task automatic watch_req(input logic [3:0] exp);
    logic [3:0] seen;
    int hits;
    seen = 4'h0;
    hits = 0;
    repeat (3) begin
      #1;
      seen = seen | auto_check_req;
      if (auto_check_req !== 4'h0) hits++;
      @(posedge clk);
    end
    chk("auto_check_req", exp, seen);
    chk("auto_req_cycles", (exp == 4'h0) ? 0 : 1, hits);
  endtask

  // One check run ends; result lines scrambled afterwards
  task automatic finish_run(input logic [15:0] f, input logic [3:0] lo);
    @(posedge clk);
    check_res <= '{f, lo};
    check_done <= 1'b1;
    @(posedge clk);
    check_done <= 1'b0;
    check_res <= '{~f, ~lo};
  endtask

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [7:0] e;
    chk("rate", AAC_FS_44K1, port_cfg.rate);
    chk("fmt", AAC_I2S, port_cfg.fmt);
    chk("slot16", 0, port_cfg.slot16);
    chk("state_cmd", 8'h55, state_cmd);
    chk("gain_level", 32'hCFCFCFCF, gain_level);
    chk("lineout_en", 0, check_cfg.lineout_en);
    chk("short_thr", 16'h1111, check_cfg.short_thr);
    for (int a = 3; a <= 16; a++) begin
      case (a)
        3: e = 8'h04;
        4, 15: e = 8'h55;
        5, 6, 7, 8: e = 8'hCF;
        10, 11: e = 8'h11;
        default: e = 8'h00;
      endcase
      rchk(8'(a), e);
    end
  endtask

  task automatic t_format();
    host.wr(8'h03, 8'hBE);
    #1;
    chk("rate", AAC_FS_96K, port_cfg.rate);
    chk("last_slots", 1, port_cfg.last_slots);
    chk("slot_base", AAC_SLOT_LAST_FIRST, port_cfg.slot_base);
    chk("slot16", 1, port_cfg.slot16);
    chk("swap_pairs", 1, port_cfg.swap_pairs);
    rchk(8'h03, 8'hBE);
    for (int f = 0; f < 7; f++) begin
      host.wr(8'h03, {2'(f % 3), 3'b000, 3'(f)});
      #1;
      chk("fmt", f, port_cfg.fmt);
      chk("rate", f % 3, port_cfg.rate);
      chk("slot_base", 0, port_cfg.slot_base);
      chk("swap_pairs", 0, port_cfg.swap_pairs);
    end
  endtask

  task automatic t_state();
    host.wr(8'h04, 8'hE4);
    watch_req(4'b1101);
    chk("state_cmd", 8'hE4, state_cmd);
    host.wr(8'h04, 8'h55);
    watch_req(4'h0);
    host.wr(8'h09, 8'h01);
    host.wr(8'h04, 8'h00);
    watch_req(4'h0);
    chan_fault <= 4'h4;
    watch_req(4'h0);
    host.wr(8'h09, 8'h00);
    chan_fault <= 4'h0;
    @(posedge clk);
    chan_fault <= 4'h2;
    watch_req(4'h2);
  endtask

  task automatic t_volume();
    host.wr(8'h05, 8'hFF);
    host.wr(8'h06, 8'h07);
    host.wr(8'h07, 8'h06);
    host.wr(8'h08, 8'h00);
    #1;
    chk("gain_level", 32'hFF070600, gain_level);
    chk("vol_mute", 4'b0011, vol_mute);
    rchk(8'h06, 8'h07);
    rchk(8'h08, 8'h00);
  endtask

  task automatic t_control();
    host.wr(8'h09, 8'hFF);
    #1;
    chk("check_abort", 1, check_abort);
    chk("ramp_cyc", 2 * AAC_RAMP_CYC, check_cfg.ramp_cyc);
    chk("settle_cyc", 2 * AAC_SETTLE_CYC, check_cfg.settle_cyc);
    chk("lineout_en", 1, check_cfg.lineout_en);
    @(posedge clk);
    #1;
    chk("check_abort", 0, check_abort);
    rchk(8'h09, 8'hE3);
    host.wr(8'h09, 8'h00);
    #1;
    chk("ramp_cyc", AAC_RAMP_CYC, check_cfg.ramp_cyc);
    chk("settle_cyc", AAC_SETTLE_CYC, check_cfg.settle_cyc);
    chk("check_abort", 0, check_abort);
    host.wr(8'h0A, 8'h90);
    host.wr(8'h0B, 8'h09);
    #1;
    chk("short_thr", 16'h9009, check_cfg.short_thr);
    rchk(8'h0A, 8'h90);
    rchk(8'h0B, 8'h09);
  endtask

  task automatic t_report();
    finish_run(16'hA53C, 4'hF);
    rchk(8'h0C, 8'hA5);
    rchk(8'h0E, 8'h00);
    host.wr(8'h09, 8'h02);
    finish_run(16'h5A00, 4'h9);
    rchk(8'h0C, 8'h5A);
    rchk(8'h0E, 8'h09);
    host.wr(8'h0C, 8'hFF);
    rchk(8'h0C, 8'h5A);
    @(posedge clk);
    state_actual <= 8'hB4;
    rchk(8'h0F, 8'hB4);
  endtask

  // Reset after the report scenario returns written settings to reset values and clears reports
  task automatic t_midreset();
    @(posedge clk);
    chan_fault <= 4'h0;
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    chk("state_cmd", 8'h55, state_cmd);
    chk("gain_level", 32'hCFCFCFCF, gain_level);
    chk("short_thr", 16'h1111, check_cfg.short_thr);
    rchk(8'h0C, 8'h00);
    rchk(8'h0E, 8'h00);
    rchk(8'h03, 8'h04);
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and hang guard
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial begin
    resetn = 1'b0;
    chan_fault = 4'h0;
    state_actual = 8'h55;
    check_done = 1'b0;
    check_res = '0;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    t_reset();
    t_format();
    t_state();
    t_volume();
    t_control();
    t_report();
    t_midreset();
    summarize();
  end

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    summarize();
  end
endmodule
